// file: verilog/extbus_pkg.sv
// Package for the external access engine: modes, timing fields and carriers
package extbus_pkg;

   // ----------------------------------------
   // Bus modes and address space
   // ----------------------------------------
   typedef enum logic [2:0] {
      EXTBUS_SINGLE_CHIP,
      EXTBUS_D16_DEMUX,
      EXTBUS_D16_MUX,
      EXTBUS_D8_MUX,
      EXTBUS_D8_DEMUX
   } extbus_mode_type;

   typedef enum logic [1:0] {
      EXTBUS_SPACE_64K,
      EXTBUS_SPACE_256K,
      EXTBUS_SPACE_1M,
      EXTBUS_SPACE_16M
   } extbus_space_type;

   localparam int EXTBUS_ADDR_W      = 24;
   localparam int EXTBUS_UPPER_W     = 8;
   localparam int EXTBUS_UPPER_LSB   = 16;
   localparam int EXTBUS_RANGES      = 5;
   localparam int EXTBUS_WAIT_W      = 4;
   localparam int EXTBUS_TRI_W       = 2;

   // Reset values of timing fields
   localparam logic [3:0] EXTBUS_WAIT_RST = 4'h0;
   localparam logic [1:0] EXTBUS_TRI_RST  = 2'h0;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   // Timing set used by one address range
   typedef struct packed {
      logic [3:0] wait_states;   // Memory cycle time
      logic [1:0] tri_cycles;    // Memory tri-state time
      logic       long_latch;    // Extra cycle of address latch pulse
      logic       strobe_delay;  // Delay read/write strobe by one cycle
      logic       ready_enable;  // Honour the wait input
   } extbus_timing_type;

   // Address window of one range: match when enabled and (addr & mask) == (base & mask)
   typedef struct packed {
      logic        enable;
      logic [7:0]  base;
      logic [7:0]  mask;
   } extbus_window_type;

   // Core-side request
   typedef struct packed {
      logic [23:0] addr;
      logic        write;
      logic        byte_acc;
      logic [15:0] wdata;
   } extbus_req_type;

endpackage

// file: verilog/extbus_range_match.sv
// Address range decoder for one chip-select window
`timescale 1ns/1ps
module extbus_range_match
   import extbus_pkg::*;
(
   // Window and address
   input  wire extbus_window_type window,
   input  wire logic [7:0]        addr_hi,
   // Result
   output logic                   hit
);
   assign hit = window.enable && ((addr_hi & window.mask) == (window.base & window.mask));
endmodule

// file: verilog/extbus_engine.sv
// External access engine: bus modes, timing, chip selects, wait and arbitration
`timescale 1ns/1ps
// Behaviour
// [RULE1] Single-chip mode or four external modes: 8/16-bit data, mux or demux.
// [RULE2] Address space limit 1M/256K/64K drives four, two or no upper lines.
// [RULE3] Full 16 MByte space drives all eight upper address lines.
// [RULE4] Demux modes: address on address port, data both ways on data port.
// [RULE5] Mux modes: data port carries address first, then data.
// [RULE6] Programmable wait states, tri-state time, latch length, strobe delay.
// [RULE7] Each address range applies its own bus timing set.
// [RULE8] Five chip-select outputs, each active for its own address range.
// [RULE9] Wait input lets slow devices lengthen an access.
// [RULE10] Hold/acknowledge arbitration; master waits for acknowledge before driving.
// [RULE11] Release request input, release acknowledge output, regain request output.
// [RULE12] Byte and word accesses anywhere in the linear space.
// [RULE13] Up to 16 MBytes of external memory addressable.
// [RULE14] Wait input high inserts wait states until it returns low.
// [RULE15] Read strobe asserted for every external read.
// [RULE16] Write strobe on every write, or only low-byte/8-bit writes by mode.
// [RULE17] Address latch enable pulses in multiplexed modes.
// [RULE18] Release acknowledge and float only after the current access ends.
// [RULE19] High-byte write strobe handles high-byte writes in low-byte mode.
module extbus_engine
   import extbus_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // Configuration
   input  wire extbus_mode_type    bus_mode,
   input  wire extbus_space_type   addr_space,
   input  wire logic               write_strobe_mode_select,
   input  wire extbus_timing_type  default_timing,
   input  wire extbus_window_type  [EXTBUS_RANGES-1:0] windows,
   input  wire extbus_timing_type  [EXTBUS_RANGES-1:0] range_timing,
   // Core request
   input  wire logic               req_valid,
   input  wire extbus_req_type     req,
   output logic                    req_ready,
   output logic                    resp_valid,
   output logic [15:0]             resp_rdata,
   output logic                    access_error,
   // Data port pins
   input  wire logic [15:0]        data_port_in,
   output logic [15:0]             data_port_out,
   output logic                    data_port_oe_n,
   // Address ports
   output logic [15:0]             address_port,
   output logic [7:0]              upper_addr,
   output logic [7:0]              upper_addr_oe_n,
   output logic                    ctrl_oe_n,
   // Strobes
   output logic                    ale,
   output logic                    read_strobe_n,
   output logic                    write_strobe_n,
   output logic                    write_high_strobe_n,
   output logic                    select_out_zero_n,
   output logic [3:1]              select_out_mid_n,
   output logic                    select_out_four_n,
   // Wait and arbitration pins
   input  wire logic               ready_pin,
   input  wire logic               hold_req_pin,
   output logic                    bus_release_ack_out_n,
   output logic                    bus_regain_request_out_n
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [1:0] ready_sync_q;
   logic [1:0] hold_sync_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_sync_q <= 2'h0;
         hold_sync_q  <= 2'h0;
      end else begin
         ready_sync_q <= {ready_sync_q[0], ready_pin};
         hold_sync_q  <= {hold_sync_q[0], hold_req_pin};
      end
   end

   wire logic ready_s = ready_sync_q[1];
   wire logic hold_s  = hold_sync_q[1];

   // ----------------------------------------
   // Range decode and timing selection
   // ----------------------------------------
   logic [EXTBUS_RANGES-1:0] hits;
   logic [EXTBUS_RANGES-1:0] sel_d;
   extbus_timing_type        tim_d;

   for (genvar g = 0; g < EXTBUS_RANGES; g++) begin : g_rng
      extbus_range_match u_match (
         .window  (windows[g]),
         .addr_hi (req.addr[23:16]),
         .hit     (hits[g])
      );
   end

   // Lowest numbered range wins when windows overlap
   always_comb begin
      sel_d = '0;
      tim_d = default_timing;
      for (int i = EXTBUS_RANGES - 1; i >= 0; i--) begin
         if (hits[i]) begin
            sel_d = '0;
            sel_d[i] = 1'b1;  // RULE8
            tim_d = range_timing[i];  // RULE7
         end
      end
   end

   // ----------------------------------------
   // Access sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_DELAY, ST_STROBE, ST_TRI, ST_HOLD
   } extbus_state_type;

   extbus_state_type  state_q;
   extbus_req_type    cur_q;
   extbus_timing_type tim_q;
   logic [4:0]        sel_q;
   logic [3:0]        cnt_q;
   logic              is_mux;
   logic              is_d8;
   logic              single_chip;
   logic              pending;
   logic              take;

   assign single_chip = (bus_mode == EXTBUS_SINGLE_CHIP);  // RULE1
   assign is_mux = (bus_mode == EXTBUS_D16_MUX) || (bus_mode == EXTBUS_D8_MUX);
   assign is_d8  = (bus_mode == EXTBUS_D8_MUX) || (bus_mode == EXTBUS_D8_DEMUX);
   assign pending = req_valid && !single_chip;
   assign take    = (state_q == ST_IDLE) && pending && !hold_s;

   // Accept only when idle so the hold handover never splits an access
   assign req_ready = (state_q == ST_IDLE) && !hold_s;  // RULE18
   assign access_error = req_valid && single_chip && (state_q == ST_IDLE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (hold_s) begin
                  state_q <= ST_HOLD;  // RULE10
               end else if (pending) begin
                  state_q <= is_mux ? ST_ADDR : (tim_d.strobe_delay ? ST_DELAY : ST_STROBE);
                  cnt_q   <= is_mux && tim_d.long_latch ? 4'h1 : 4'h0;
                  if (!is_mux) begin
                     cnt_q <= tim_d.wait_states;
                  end
               end
            end
            ST_ADDR: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;  // RULE6
               end else begin
                  state_q <= tim_q.strobe_delay ? ST_DELAY : ST_STROBE;
                  cnt_q   <= tim_q.wait_states;
               end
            end
            ST_DELAY: state_q <= ST_STROBE;
            ST_STROBE: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;  // RULE6
               end else if (!(tim_q.ready_enable && ready_s)) begin  // RULE9 RULE14
                  state_q <= ST_TRI;
                  cnt_q   <= {2'h0, tim_q.tri_cycles};
               end
            end
            ST_TRI: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_HOLD: begin
               if (!hold_s) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Latched request, timing and selects for the access in flight
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
         tim_q <= '0;
         sel_q <= 5'h00;
      end else if (take) begin
         cur_q <= req;  // RULE12 RULE13
         tim_q <= tim_d;
         sel_q <= sel_d;
      end else if (state_q == ST_IDLE) begin
         sel_q <= 5'h00;
      end
   end

   // Read data capture and completion pulse
   wire logic strobe_last = (state_q == ST_STROBE) && (cnt_q == 4'h0)
                            && !(tim_q.ready_enable && ready_s);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_rdata <= 16'h0000;
      end else begin
         resp_valid <= strobe_last;
         if (strobe_last && !cur_q.write) begin
            resp_rdata <= is_d8 ? {8'h00, data_port_in[7:0]} : data_port_in;
         end
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic in_access;
   logic held;
   logic low_byte;
   logic high_byte;

   assign in_access = (state_q != ST_IDLE) && (state_q != ST_HOLD);
   assign held      = (state_q == ST_HOLD);
   assign low_byte  = !cur_q.byte_acc || !cur_q.addr[0];
   assign high_byte = !cur_q.byte_acc || cur_q.addr[0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         address_port   <= 16'h0000;
         upper_addr     <= 8'h00;
         data_port_out  <= 16'h0000;
      end else if (take) begin
         // Loaded at the take edge so the pins are already valid in the first bus cycle
         address_port  <= req.addr[15:0];  // RULE4
         upper_addr    <= req.addr[23:16];
         data_port_out <= is_mux ? req.addr[15:0]  // RULE5
                                 : (is_d8 ? {req.addr[15:8], req.wdata[7:0]} : req.wdata);
      end else if (state_q == ST_ADDR && cnt_q == 4'h0) begin
         // Mux modes swap the address for write data as the latch phase ends
         data_port_out <= is_d8 ? {cur_q.addr[15:8], cur_q.wdata[7:0]} : cur_q.wdata;
      end
   end

   always_comb begin
      case (addr_space)
         EXTBUS_SPACE_64K:  upper_addr_oe_n = 8'hFF;  // RULE2
         EXTBUS_SPACE_256K: upper_addr_oe_n = 8'hFC;
         EXTBUS_SPACE_1M:   upper_addr_oe_n = 8'hF0;
         EXTBUS_SPACE_16M:  upper_addr_oe_n = 8'h00;  // RULE3
         default:           upper_addr_oe_n = 8'hFF;
      endcase
      if (held || single_chip) begin
         upper_addr_oe_n = 8'hFF;  // RULE18
      end
   end

   assign ctrl_oe_n = held;
   // Data port drives during the address phase in mux modes and for writes
   assign data_port_oe_n = !((is_mux && state_q == ST_ADDR)
                             || (cur_q.write && (state_q == ST_DELAY || state_q == ST_STROBE)));
   assign ale = is_mux && (state_q == ST_ADDR);  // RULE17

   wire logic strobing = (state_q == ST_STROBE);
   assign read_strobe_n  = !(strobing && !cur_q.write);  // RULE15
   // Low-byte mode gates the write strobe; full mode fires on every write
   assign write_strobe_n = !(strobing && cur_q.write
                            && (!write_strobe_mode_select || is_d8 || low_byte));  // RULE16
   assign write_high_strobe_n = !(strobing && cur_q.write && write_strobe_mode_select
                                  && !is_d8 && high_byte);  // RULE19

   assign select_out_zero_n = !(in_access && sel_q[0]);  // RULE8
   assign select_out_mid_n  = ~(sel_q[3:1] & {3{in_access}});
   assign select_out_four_n = !(in_access && sel_q[4]);

   assign bus_release_ack_out_n    = !held;  // RULE11
   assign bus_regain_request_out_n = !(held && pending);  // RULE11

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_release;
      held ##1 !bus_release_ack_out_n;
   endsequence

   AST_NO_ACK_MIDACCESS: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE18
      in_access |-> bus_release_ack_out_n) else $error("release ack during access");
   AST_ACK_FLOATS: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE10
      !bus_release_ack_out_n |-> (ctrl_oe_n && upper_addr_oe_n == 8'hFF && data_port_oe_n))
      else $error("bus driven while released");
   AST_HOLD_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE11
      (state_q == ST_IDLE && hold_s) |=> s_release) else $error("hold not acknowledged");
   AST_ALE_MUX_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE17
      ale |-> is_mux && !data_port_oe_n) else $error("latch pulse outside mux address");
   AST_NO_RD_WR_TOGETHER: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE15
      !(!read_strobe_n && !write_strobe_n)) else $error("read and write strobes together");
   AST_WAIT_EXTENDS: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE14
      (strobing && cnt_q == 4'h0 && tim_q.ready_enable && ready_s) |=> strobing)
      else $error("wait input ignored");
   AST_SPACE_64K: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE2
      (addr_space == EXTBUS_SPACE_64K) |-> upper_addr_oe_n == 8'hFF)
      else $error("upper lines driven in 64K space");
   AST_SINGLE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE1
      (single_chip && state_q == ST_IDLE) |=> !ale && read_strobe_n && write_strobe_n)
      else $error("external access in single chip mode");
   AST_ONE_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)  // RULE8
      $onehot0(~{select_out_four_n, select_out_mid_n, select_out_zero_n}))
      else $error("several chip selects active");

endmodule

// file: sim/extbus_far_model.sv
// Far-side model: byte memory, slow device on the wait input, alternate bus master
`timescale 1ns/1ps
module extbus_far_model
   import extbus_pkg::*;
(
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst_n,
   // Bus pins
   input  wire extbus_mode_type bus_mode,
   input  wire logic            wsel,
   input  wire logic [15:0]     data_port_out,
   input  wire logic [15:0]     address_port,
   input  wire logic            ale,
   input  wire logic            read_strobe_n,
   input  wire logic            write_strobe_n,
   input  wire logic            write_high_strobe_n,
   output logic [15:0]          data_port_in,
   // Wait and arbitration
   input  wire logic [3:0]      slow,
   input  wire logic            want_hold,
   input  wire logic            bus_release_ack_out_n,
   input  wire logic            bus_regain_request_out_n,
   output logic                 ready_pin,
   output logic                 hold_req_pin
);
   logic [7:0]  mem [0:255];
   logic [7:0]  adr_q;
   logic [7:0]  a;
   logic [15:0] last_q;
   logic [3:0]  cnt_q;
   logic        gave_q;
   logic        mux;
   logic        d8;
   logic        act;
   assign mux = bus_mode inside {EXTBUS_D16_MUX, EXTBUS_D8_MUX};
   assign d8 = bus_mode inside {EXTBUS_D8_MUX, EXTBUS_D8_DEMUX};
   assign a = mux ? adr_q : address_port[7:0];
   assign act = !read_strobe_n || !write_strobe_n || !write_high_strobe_n;
   // Released lanes show the inverse of the last value, so a stale copy never passes
   assign data_port_in = read_strobe_n ? ~last_q : d8 ? {~last_q[15:8], mem[a]}
                         : {mem[a | 8'h01], mem[a & 8'hFE]};
   assign ready_pin = act && cnt_q < slow;
   // Never touches the bus itself, so it only asks and drops the request on the regain request
   assign hold_req_pin = want_hold && !gave_q;
   always_ff @(posedge core_clk) begin
      if (ale)
         adr_q <= data_port_out[7:0];
      if (!write_strobe_n)
         mem[d8 ? a : a & 8'hFE] <= data_port_out[7:0];
      if (!d8 && (!write_high_strobe_n || (!wsel && !write_strobe_n)))
         mem[a | 8'h01] <= data_port_out[15:8];
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         gave_q <= 1'b0;
         last_q <= 16'h5A5A;
      end else begin
         cnt_q <= act ? cnt_q + 4'((cnt_q != 4'hF)) : 4'h0;
         if (!read_strobe_n)
            last_q <= data_port_in;
         if (!want_hold)
            gave_q <= 1'b0;
         else if (!bus_regain_request_out_n)
            gave_q <= 1'b1;
      end
   end
endmodule

// file: sim/tb.sv
// Self-checking bench for the external access engine
`timescale 1ns/1ps
module tb;
   import extbus_pkg::*;
   logic                                  core_clk, rst_n, wsel, want_hold, req_valid;
   extbus_mode_type                       bus_mode;
   extbus_space_type                      addr_space;
   extbus_timing_type                     default_timing;
   extbus_window_type [EXTBUS_RANGES-1:0] windows;
   extbus_timing_type [EXTBUS_RANGES-1:0] range_timing;
   extbus_req_type                        req;
   logic                                  req_ready, resp_valid, access_error, ale;
   logic [15:0]                           resp_rdata, data_port_in, data_port_out;
   logic [15:0]                           address_port, rdat;
   logic [7:0]                            upper_addr, upper_addr_oe_n;
   logic                                  data_port_oe_n, ctrl_oe_n, read_strobe_n;
   logic                                  write_strobe_n, write_high_strobe_n;
   logic                                  select_out_zero_n, select_out_four_n;
   logic [3:1]                            select_out_mid_n;
   logic                                  ready_pin, hold_req_pin;
   logic                                  bus_release_ack_out_n, bus_regain_request_out_n;
   logic [3:0]                            slow;
   logic [4:0]                            cs_seen;
   logic                                  rd_seen, wr_seen, wh_seen, ale_seen, rg_seen;
   logic [31:0]                           rnd;
   int                                    errors, total_checks, cyc, lat;
   logic [7:0]                            exp_mem [int];
   extbus_mode_type modes [4] = '{EXTBUS_D16_DEMUX, EXTBUS_D16_MUX, EXTBUS_D8_MUX,
                                  EXTBUS_D8_DEMUX};
   logic [7:0] spc [4] = '{8'hFF, 8'hFC, 8'hF0, 8'h00};
   // Each entry: 8-bit bus, low-byte strobe mode, odd address, low strobe expected
   logic [3:0] wtab [4] = '{4'b0011, 4'b0110, 4'b0101, 4'b1111};

   extbus_engine dut (
      .core_clk, .rst_n, .bus_mode, .addr_space, .write_strobe_mode_select(wsel),
      .default_timing, .windows, .range_timing, .req_valid, .req, .req_ready,
      .resp_valid, .resp_rdata, .access_error, .data_port_in, .data_port_out,
      .data_port_oe_n, .address_port, .upper_addr, .upper_addr_oe_n, .ctrl_oe_n, .ale,
      .read_strobe_n, .write_strobe_n, .write_high_strobe_n, .select_out_zero_n,
      .select_out_mid_n, .select_out_four_n, .ready_pin, .hold_req_pin,
      .bus_release_ack_out_n, .bus_regain_request_out_n);
   extbus_far_model far (
      .core_clk, .rst_n, .bus_mode, .wsel, .data_port_out, .address_port, .ale,
      .read_strobe_n, .write_strobe_n, .write_high_strobe_n, .data_port_in, .slow,
      .want_hold, .bus_release_ack_out_n, .bus_regain_request_out_n, .ready_pin,
      .hold_req_pin);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic bit mux_m();
      return bus_mode inside {EXTBUS_D16_MUX, EXTBUS_D8_MUX};
   endfunction
   function automatic bit d8_m();
      return bus_mode inside {EXTBUS_D8_MUX, EXTBUS_D8_DEMUX};
   endfunction
   function automatic extbus_timing_type tmg(logic [3:0] w, logic [1:0] t, logic l, d, r);
      return '{wait_states: w, tri_cycles: t, long_latch: l, strobe_delay: d, ready_enable: r};
   endfunction
   function automatic int elat(extbus_timing_type t);
      return (mux_m() ? 2 + int'(t.long_latch) : 1) + int'(t.strobe_delay) + int'(t.wait_states);
   endfunction
   function automatic logic [15:0] exp_rd(logic [7:0] a);
      return d8_m() ? {8'h00, exp_mem[a]} : {exp_mem[a | 8'h01], exp_mem[a]};
   endfunction
   task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (exp !== got) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic acc(input logic w, b, input logic [23:0] ad, input logic [15:0] wd);
      int n;
      n = 0;
      req = '{addr: ad, write: w, byte_acc: b, wdata: wd};
      req_valid = 1;
      rg_seen = 0;
      while (!req_ready && n < 60) begin
         @(posedge core_clk);
         #1 n++;
      end
      // Cleared only now so a select still up in the previous tri phase is not counted
      {rd_seen, wr_seen, wh_seen, ale_seen, cs_seen} = '0;
      @(posedge core_clk);
      #1 req_valid = 0;
      lat = 0;
      while (!resp_valid && lat < 60) begin
         @(posedge core_clk);
         #1 lat++;
      end
      rdat = resp_rdata;
      if (w && !b) begin
         exp_mem[ad[7:0]] = wd[7:0];
         if (!d8_m())
            exp_mem[ad[7:0] | 8'h01] = wd[15:8];
      end
   endtask

   // ----------------------------------------
   // Clock, monitors and sequence
   // ----------------------------------------
   initial begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      rd_seen |= !read_strobe_n;
      wr_seen |= !write_strobe_n;
      wh_seen |= !write_high_strobe_n;
      ale_seen |= ale;
      rg_seen |= !bus_regain_request_out_n;
      cs_seen |= ~{select_out_four_n, select_out_mid_n, select_out_zero_n};
      if (!bus_release_ack_out_n)
         check("ack_during_strobe", 0, !read_strobe_n || !write_strobe_n);
      cyc++;
      if (cyc > 20000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      {rst_n, wsel, want_hold, req_valid, slow, req, windows, range_timing} = '0;
      {default_timing, errors, total_checks, cyc} = '0;
      bus_mode = EXTBUS_SINGLE_CHIP;
      addr_space = EXTBUS_SPACE_16M;
      rnd = 32'h0573;
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1;
      req_valid = 1;
      @(posedge core_clk);
      #1 check("access_error", 1, access_error);
      req_valid = 0;
      repeat (3) @(posedge core_clk);
      #1 check("single_chip_resp", 0, resp_valid);
      foreach (modes[i]) begin
         bus_mode = modes[i];
         repeat (3) begin
            rnd = lfsr(rnd);
            default_timing = tmg(rnd[3:0], rnd[5:4], rnd[6], rnd[7], 1'b0);
            acc(1, 0, {16'h0000, rnd[15:9], 1'b0}, rnd[31:16]);
            check("write_lat", elat(default_timing), lat);
            check("write_strobe", 1, wr_seen);
            check("ale", mux_m(), ale_seen);
            acc(0, 0, {16'h0000, rnd[15:9], 1'b0}, 16'h0000);
            check("read_lat", elat(default_timing), lat);
            check("read_strobe", 1, rd_seen);
            check("read_data", exp_rd({rnd[15:9], 1'b0}), rdat);
         end
      end
      bus_mode = EXTBUS_D16_DEMUX;
      default_timing = '0;
      for (int s = 0; s < 4; s++) begin
         addr_space = extbus_space_type'(s);
         acc(0, 0, 24'h000010, 16'h0000);
         check("upper_oe_n", spc[s], upper_addr_oe_n);
      end
      for (int i = 0; i < EXTBUS_RANGES; i++) begin
         windows[i] = '{enable: 1'b1, base: 8'(i + 1), mask: 8'hFF};
         range_timing[i] = tmg(4'(3 * i), 2'h0, 1'b0, 1'b0, 1'b0);
      end
      for (int i = 0; i < EXTBUS_RANGES; i++) begin
         acc(0, 0, {8'(i + 1), 16'h0010}, 16'h0000);
         check("select", 5'h01 << i, cs_seen);
         check("range_lat", 1 + 3 * i, lat);
         check("upper_addr", i + 1, upper_addr);
      end
      windows = '0;
      foreach (wtab[k]) begin
         bus_mode = wtab[k][3] ? EXTBUS_D8_DEMUX : EXTBUS_D16_DEMUX;
         wsel = wtab[k][2];
         acc(1, 1, {16'h0000, 7'h20, wtab[k][1]}, 16'hA55A);
         check("write_low", wtab[k][0], wr_seen);
         if (wsel && !d8_m())
            check("write_high", wtab[k][1], wh_seen);
      end
      wsel = 0;
      bus_mode = EXTBUS_D16_DEMUX;
      slow = 4'h8;
      default_timing = tmg(4'h3, 2'h0, 1'b0, 1'b0, 1'b1);
      acc(0, 0, 24'h000010, 16'h0000);
      check("ready_stretch", 1, lat > 4);
      default_timing.ready_enable = 0;
      acc(0, 0, 24'h000010, 16'h0000);
      check("ready_ignored", 4, lat);
      slow = 0;
      default_timing = tmg(4'h5, 2'h1, 1'b0, 1'b0, 1'b0);
      fork
         acc(0, 0, 24'h000010, 16'h0000);
         begin
            repeat (2) @(posedge core_clk);
            #1 want_hold = 1;
         end
      join
      repeat (10) if (bus_release_ack_out_n) @(posedge core_clk);
      #1 check("hold_ack_n", 0, bus_release_ack_out_n);
      check("ctrl_oe_n", 1, ctrl_oe_n);
      check("data_oe_n", 1, data_port_oe_n);
      check("ready_in_hold", 0, req_ready);
      acc(0, 0, 24'h000010, 16'h0000);
      check("regain_request", 1, rg_seen);
      check("regain_lat", 6, lat);
      want_hold = 0;
      wrap_up();
   end
endmodule
